// File: rtl/ccmbf_defs.vh
// Purpose: Constants for the CCM block formatter
// Assumes: Octet 0 of a block sits in bits [127:120]
// Notes:   Definitions only
`ifndef CCMBF_DEFS_VH
`define CCMBF_DEFS_VH

`define CCMBF_FLAGS_B0      8'h59
`define CCMBF_FLAGS_AI      8'h01
`define CCMBF_BLK_OCTETS    5'h10
`define CCMBF_KIND_B0       3'h0
`define CCMBF_KIND_B1       3'h1
`define CCMBF_KIND_PLAIN    3'h2
`define CCMBF_KIND_ENC      3'h3
`define CCMBF_KIND_CTR      3'h4
`define CCMBF_ADATA_BASE    16'h000e
`define CCMBF_FIFO_DEPTH    16
`define CCMBF_FIFO_AW       4

`endif

// File: rtl/ccmbf_mem.v
// Purpose: Small dual-port memory for the block FIFO
// Assumes: One write and one read port on one clock
// Notes:   Read data come out of a register
`timescale 1ns/1ps

module ccmbf_mem #(
  parameter WIDTH = 131,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data_q
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule // ccmbf_mem

// File: rtl/ccmbf_fifo.v
// Purpose: Block FIFO between the formatter and the AES core
// Assumes: Single clock, active-low reset already synchronised
// Notes:   Output stage is a register fed from the memory
`timescale 1ns/1ps

module ccmbf_fifo #(
  parameter WIDTH = 131,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid_q,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_q
);

  reg  [AW:0]       wr_ptr_q;
  reg  [AW:0]       rd_ptr_q;
  reg               mem_ok_q;
  wire [WIDTH-1:0]  mem_q;
  wire              full;
  wire              empty;
  wire              push;
  wire              pop_mem;
  wire              out_free;

  assign full     = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
  assign empty    = (wr_ptr_q == rd_ptr_q);
  assign in_ready = !full;
  assign push     = in_valid && !full;
  assign out_free = !out_valid_q || out_ready;
  // Memory read address is launched one cycle ahead of the output load
  assign pop_mem  = !empty && !mem_ok_q && out_free;

  ccmbf_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk       (clk),
    .wr_en     (push),
    .wr_addr   (wr_ptr_q[AW-1:0]),
    .wr_data   (in_data),
    .rd_addr   (rd_ptr_q[AW-1:0]),
    .rd_data_q (mem_q)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q    <= {(AW+1){1'b0}};
      rd_ptr_q    <= {(AW+1){1'b0}};
      mem_ok_q    <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (mem_ok_q) begin
        out_valid_q <= 1'b1;
        out_data_q  <= mem_q;
        mem_ok_q    <= 1'b0;
        rd_ptr_q    <= rd_ptr_q + 1'b1;
      end else begin
        if (out_valid_q && out_ready) begin
          out_valid_q <= 1'b0;
        end
        mem_ok_q <= pop_mem;
      end
    end
  end

endmodule // ccmbf_fifo

// File: rtl/ccmbf_top.v
// Purpose: Forms CCM authentication and counter blocks for secure frames
// Assumes: Payload octets arrive in air order, one per cycle, valid/ready
// Notes:   Blocks leave through a FIFO towards the AES core, one per handshake
`timescale 1ns/1ps
`include "ccmbf_defs.vh"

// What this block does
// - After B0 and B1 the plain portion is cut into 16-octet blocks, then the encrypted one.
// - The last plain-portion block is zero-filled to 16 octets with 0 to 15 zero octets.
// - The last encrypted-portion block is zero-filled on its own, independent of the first.
// - Fill zeros go only to the MAC path and never back into the transmitted payload.
// - Payload octets sit in air order with the first octet in the most significant place.
// - Fill zeros of a short last block take the rightmost octet places.
// - Each counter block is flags 0x01, the 13-octet nonce and a 2-octet counter.
// - The counter starts at zero for every frame and steps by one per counter block.
// - The counter field is placed most significant octet first.
// - The nonce inside counter blocks is placed least significant octet first.
// - Counter blocks go to AES to make key stream for the MAC value and encrypted payload.
// - CCM runs with an 8-octet tag and a 2-octet length field.
// - The nonce is source, destination, temporal key id and secure frame number, in order.
// - B0 is flags 0x59, the reversed nonce and the encrypted length, high octet first.
// - B1 is the additional length, 10-octet header, offset, reserved octet and a zero.
module ccmbf_top #(
  parameter DEPTH = `CCMBF_FIFO_DEPTH,
  parameter AW    = `CCMBF_FIFO_AW
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         frame_start,
  input  wire [15:0]  source_addr,
  input  wire [15:0]  destination_addr,
  input  wire [23:0]  temporal_key_id,
  input  wire [47:0]  secure_frame_number,
  input  wire [79:0]  mac_header,
  input  wire [15:0]  payload_len,
  input  wire [15:0]  encryption_offset,
  input  wire [7:0]   sec_reserved,
  input  wire [15:0]  ctr_blocks,
  output reg          start_ready_q,
  input  wire         pl_valid,
  input  wire [7:0]   pl_data,
  output reg          pl_ready_q,
  output reg          aes_valid_q,
  output reg  [127:0] aes_block_q,
  output reg  [2:0]   aes_kind_q,
  input  wire         aes_ready,
  output reg          frame_done_q
);

  // -----------------------------------------------------------------
  // FIFO word width and sequencer states
  // -----------------------------------------------------------------
  // FIFO word is the 3-bit block kind above the 128-bit block
  localparam WIDTH = 131;

  localparam ST_IDLE  = 3'h0;
  localparam ST_B0    = 3'h1;
  localparam ST_B1    = 3'h2;
  localparam ST_PLAIN = 3'h3;
  localparam ST_ENC   = 3'h4;
  localparam ST_CTR   = 3'h5;
  localparam ST_DONE  = 3'h6;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  // Nonce with its least significant octet leftmost
  function [103:0] rev_nonce;
    input [103:0] n;
    integer k;
    begin
      rev_nonce = 104'h0;
      for (k = 0; k < 13; k = k + 1) begin
        rev_nonce[8*(12-k) +: 8] = n[8*k +: 8];
      end
    end
  endfunction

  // Insert one octet at position idx (0 = leftmost) of a block
  function [127:0] put_octet;
    input [127:0] blk;
    input [3:0]   idx;
    input [7:0]   oct;
    begin
      put_octet = blk;
      put_octet[8*(15-idx) +: 8] = oct;
    end
  endfunction

  // An octet closes its block when it fills the last place or ends its portion
  function block_closes;
    input [3:0] idx;
    input       last;
    begin
      block_closes = (idx == 4'hf) || last;
    end
  endfunction

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  reg rst_s1_q;
  reg rst_n_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // -----------------------------------------------------------------
  // Frame registers and sequencer
  // -----------------------------------------------------------------
  reg  [2:0]   state_q;
  reg  [103:0] nonce_q;
  reg  [79:0]  hdr_q;
  reg  [15:0]  eo_q;
  reg  [15:0]  mlen_q;
  reg  [7:0]   resv_q;
  reg  [15:0]  plain_left_q;
  reg  [15:0]  enc_left_q;
  reg  [15:0]  ctr_q;
  reg  [15:0]  ctr_last_q;
  reg  [127:0] acc_q;
  reg  [3:0]   pos_q;
  reg  [127:0] push_blk;
  reg  [2:0]   push_kind;
  reg          push_en;
  wire         fifo_in_ready;
  wire         fifo_out_valid;
  wire [WIDTH-1:0] fifo_out_data;
  wire         take_octet;
  wire [127:0] acc_next;
  wire         portion_last;
  wire [15:0]  left_now;
  wire         close_now;

  assign left_now     = (state_q == ST_PLAIN) ? plain_left_q : enc_left_q;
  assign take_octet   = pl_ready_q && pl_valid;
  assign acc_next     = put_octet(acc_q, pos_q, pl_data);
  assign portion_last = (left_now == 16'h0001);
  assign close_now    = take_octet && block_closes(pos_q, portion_last);

  // -----------------------------------------------------------------
  // Block source mux
  // -----------------------------------------------------------------
  always @* begin
    push_en   = 1'b0;
    push_kind = `CCMBF_KIND_B0;
    push_blk  = 128'h0;
    case (state_q)
      ST_B0: begin
        push_en  = 1'b1;
        push_blk = {`CCMBF_FLAGS_B0, rev_nonce(nonce_q), mlen_q};
      end
      ST_B1: begin
        push_en   = 1'b1;
        push_kind = `CCMBF_KIND_B1;
        // Additional length counts header, offset field, reserved and zero octets (14) plus plain octets
        push_blk  = {`CCMBF_ADATA_BASE + eo_q, hdr_q, eo_q, resv_q, 8'h00};
      end
      ST_PLAIN, ST_ENC: begin
        // Untaken octets of acc stay zero, so a short block is filled on the right
        push_en   = close_now;
        push_kind = (state_q == ST_PLAIN) ? `CCMBF_KIND_PLAIN : `CCMBF_KIND_ENC;
        push_blk  = acc_next;
      end
      ST_CTR: begin
        push_en   = 1'b1;
        push_kind = `CCMBF_KIND_CTR;
        push_blk  = {`CCMBF_FLAGS_AI, rev_nonce(nonce_q), ctr_q};
      end
      default: begin
        push_en = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Sequencer registers
  // -----------------------------------------------------------------
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q       <= ST_IDLE;
      nonce_q       <= 104'h0;
      hdr_q         <= 80'h0;
      eo_q          <= 16'h0;
      mlen_q        <= 16'h0;
      resv_q        <= 8'h0;
      plain_left_q  <= 16'h0;
      enc_left_q    <= 16'h0;
      ctr_q         <= 16'h0;
      ctr_last_q    <= 16'h0;
      acc_q         <= 128'h0;
      pos_q         <= 4'h0;
      start_ready_q <= 1'b0;
      pl_ready_q    <= 1'b0;
      frame_done_q  <= 1'b0;
    end else begin
      frame_done_q  <= 1'b0;
      start_ready_q <= (state_q == ST_IDLE) && !frame_start;
      pl_ready_q    <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (frame_start && start_ready_q) begin
            nonce_q      <= {source_addr, destination_addr, temporal_key_id,
                             secure_frame_number};
            hdr_q        <= mac_header;
            eo_q         <= encryption_offset;
            mlen_q       <= payload_len - encryption_offset;
            resv_q       <= sec_reserved;
            plain_left_q <= encryption_offset;
            enc_left_q   <= payload_len - encryption_offset;
            ctr_q        <= 16'h0;
            ctr_last_q   <= ctr_blocks;
            acc_q        <= 128'h0;
            pos_q        <= 4'h0;
            state_q      <= ST_B0;
          end
        end
        ST_B0: begin
          if (fifo_in_ready) begin
            state_q <= ST_B1;
          end
        end
        ST_B1: begin
          if (fifo_in_ready) begin
            state_q <= (eo_q != 16'h0) ? ST_PLAIN :
                       (mlen_q != 16'h0) ? ST_ENC : ST_CTR;
          end
        end
        ST_PLAIN, ST_ENC: begin
          // Ready drops for a cycle after each push, so it is only raised
          // when the FIFO is seen with room for the next block-closing octet
          pl_ready_q <= fifo_in_ready && !close_now;
          if (take_octet) begin
            if (close_now) begin
              acc_q <= 128'h0;
              pos_q <= 4'h0;
            end else begin
              acc_q <= acc_next;
              pos_q <= pos_q + 4'h1;
            end
            if (state_q == ST_PLAIN) begin
              plain_left_q <= plain_left_q - 16'h0001;
              if (portion_last) begin
                state_q <= (enc_left_q != 16'h0) ? ST_ENC : ST_CTR;
              end
            end else begin
              enc_left_q <= enc_left_q - 16'h0001;
              if (portion_last) begin
                state_q <= ST_CTR;
              end
            end
          end
        end
        ST_CTR: begin
          if (fifo_in_ready) begin
            ctr_q <= ctr_q + 16'h0001;
            if (ctr_q == ctr_last_q) begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          frame_done_q <= 1'b1;
          state_q      <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Block FIFO and AES-side register stage
  // -----------------------------------------------------------------
  // Payload octets are only read here, never rewritten, so fill zeros stay off the air
  ccmbf_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .clk         (clk),
    .rst_n       (rst_n_q),
    .in_valid    (push_en),
    .in_ready    (fifo_in_ready),
    .in_data     ({push_kind, push_blk}),
    .out_valid_q (fifo_out_valid),
    .out_ready   (aes_ready),
    .out_data_q  (fifo_out_data)
  );

  // -----------------------------------------------------------------
  // AES-side outputs, taken straight from the FIFO output register
  // -----------------------------------------------------------------
  always @* begin
    aes_valid_q = fifo_out_valid;
    aes_kind_q  = fifo_out_data[130:128];
    aes_block_q = fifo_out_data[127:0];
  end

endmodule // ccmbf_top

// File: verif/ccmbf_props.sv
// Purpose: Assertions on the block stream of the formatter
// Assumes: Sees top-level ports only
// Notes:   Bound into ccmbf_top below
`timescale 1ns/1ps
module ccmbf_props (
  input wire         clk,
  input wire         rst_b,
  input wire         frame_start,
  input wire         start_ready_q,
  input wire         aes_valid_q,
  input wire [127:0] aes_block_q,
  input wire [2:0]   aes_kind_q,
  input wire         aes_ready
);
  reg         seen_q;
  reg [15:0]  ctr_q;
  reg [2:0]   kind_q;
  reg [103:0] nonce_q;
  wire        hs = aes_valid_q && aes_ready;
  // ---------------------------------------------
  // Memory of the last block accepted by the core
  // ---------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= 1'b0;
      ctr_q <= 16'h0000;
      kind_q <= 3'h0;
      nonce_q <= 104'h0;
    end else if (hs) begin
      kind_q <= aes_kind_q;
      if (aes_kind_q == 3'h4) begin
        seen_q <= 1'b1;
        ctr_q <= aes_block_q[15:0];
      end
      if (aes_kind_q == 3'h0) begin
        seen_q <= 1'b0;
        nonce_q <= aes_block_q[119:16];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_stall;
    aes_valid_q && !aes_ready;
  endsequence
  sequence s_ctr;
    hs && aes_kind_q == 3'h4;
  endsequence
  a_block_held_stall: assert property (s_stall |=> aes_valid_q && $stable(aes_block_q)
    && $stable(aes_kind_q)) else $error("block changed while stalled");
  a_kind_order_kept: assert property (hs |-> aes_kind_q >= kind_q || aes_kind_q == 3'h0)
    else $error("block kinds out of order");
  a_b0_flags_value: assert property (hs && aes_kind_q == 3'h0 |-> aes_block_q[127:120] == 8'h59)
    else $error("first block flags wrong");
  a_b1_zero_tail: assert property (hs && aes_kind_q == 3'h1 |-> aes_block_q[7:0] == 8'h00)
    else $error("second block last octet not zero");
  a_ctr_flags_value: assert property (s_ctr |-> aes_block_q[127:120] == 8'h01)
    else $error("counter block flags wrong");
  a_ctr_starts_zero: assert property (s_ctr and !seen_q |-> aes_block_q[15:0] == 16'h0000)
    else $error("counter did not start at zero");
  a_ctr_steps_one: assert property (s_ctr and seen_q |-> aes_block_q[15:0] == ctr_q + 16'h0001)
    else $error("counter step not one");
  a_ctr_nonce_same: assert property (s_ctr |-> aes_block_q[119:16] == nonce_q)
    else $error("counter block nonce differs");
  a_start_taken_once: assert property (frame_start && start_ready_q |=> !start_ready_q)
    else $error("start not taken");
endmodule // ccmbf_props
bind ccmbf_top ccmbf_props i_props (.clk(clk), .rst_b(rst_b), .frame_start(frame_start),
  .start_ready_q(start_ready_q), .aes_valid_q(aes_valid_q), .aes_block_q(aes_block_q),
  .aes_kind_q(aes_kind_q), .aes_ready(aes_ready));

// File: verif/ccmbf_aes_model.sv
// Purpose: Acceptance side of the AES core
// Assumes: Mode 0 prompt, 1 every fourth cycle, 2 long stall
// Notes:   Only takes blocks, no cipher
`timescale 1ns/1ps
module ccmbf_aes_model (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [1:0] stall_mode,
  input  wire       aes_valid_q,
  output reg        aes_ready
);
  reg [5:0] wait_q;
  reg [1:0] ph_q;
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 6'h00;
      ph_q <= 2'h0;
      aes_ready <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (!aes_valid_q)
        wait_q <= 6'h00;
      else if (wait_q != 6'h3f)
        wait_q <= wait_q + 6'h01;
      case (stall_mode)
        2'h0: aes_ready <= 1'b1;
        2'h1: aes_ready <= (ph_q == 2'h3);
        default: aes_ready <= (wait_q[5:4] == 2'h3);
      endcase
    end
  end
endmodule // ccmbf_aes_model

// File: verif/tb_top.sv
// Purpose: Self-checking bench of the formatter
// Assumes: Inputs change at the falling edge
// Notes:   Every accepted block is compared with a queue
`timescale 1ns/1ps
module tb_top;
  reg          clk, rst_b, frame_start, pl_valid;
  reg  [15:0]  source_addr, destination_addr, payload_len, encryption_offset, ctr_blocks;
  reg  [23:0]  temporal_key_id;
  reg  [47:0]  secure_frame_number;
  reg  [79:0]  mac_header;
  reg  [7:0]   sec_reserved, pl_data;
  reg  [1:0]   stall_mode;
  wire         start_ready_q, pl_ready_q, aes_valid_q, aes_ready, frame_done_q;
  wire [127:0] aes_block_q;
  wire [2:0]   aes_kind_q;
  reg  [130:0] exp_q[$];
  integer      errors, num_checks;
  ccmbf_top i_dut (.clk(clk), .rst_b(rst_b), .frame_start(frame_start),
    .source_addr(source_addr), .destination_addr(destination_addr),
    .temporal_key_id(temporal_key_id), .secure_frame_number(secure_frame_number),
    .mac_header(mac_header), .payload_len(payload_len), .encryption_offset(encryption_offset),
    .sec_reserved(sec_reserved), .ctr_blocks(ctr_blocks), .start_ready_q(start_ready_q),
    .pl_valid(pl_valid), .pl_data(pl_data), .pl_ready_q(pl_ready_q),
    .aes_valid_q(aes_valid_q), .aes_block_q(aes_block_q), .aes_kind_q(aes_kind_q),
    .aes_ready(aes_ready), .frame_done_q(frame_done_q));
  ccmbf_aes_model i_aes (.clk(clk), .rst_b(rst_b), .stall_mode(stall_mode),
    .aes_valid_q(aes_valid_q), .aes_ready(aes_ready));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task check(input [130:0] seen, input [130:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        errors = errors + 1;
        $display("[FAIL] %0t got %h want %h", $time, seen, want);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d checks %0d", errors, num_checks);
      if (errors == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  function [103:0] nonce_rev(input [103:0] v);
    integer i;
    begin
      for (i = 0; i < 13; i = i + 1)
        nonce_rev[8*i +: 8] = v[8*(12-i) +: 8];
    end
  endfunction
  function [7:0] pbyte(input integer k);
    pbyte = k * 29 + 91;
  endfunction
  // ---------------------------------------------
  // Every block taken by the core
  // ---------------------------------------------
  always @(posedge clk) begin
    if (aes_valid_q === 1'b1 && aes_ready === 1'b1) begin
      if (exp_q.size() == 0)
        check({aes_kind_q, aes_block_q}, 131'h0);
      else
        check({aes_kind_q, aes_block_q}, exp_q.pop_front());
    end
  end
  task run_frame(input [15:0] p, input [15:0] eo, input [15:0] nc, input [1:0] sm,
                 input integer hold);
    reg [103:0] n;
    reg [127:0] b;
    integer     k, j, w;
    begin
      @(negedge clk);
      stall_mode <= sm;
      payload_len = p;
      encryption_offset = eo;
      ctr_blocks = nc;
      secure_frame_number = secure_frame_number + 48'h1;
      mac_header = {mac_header[71:0], mac_header[79:72]};
      n = {source_addr, destination_addr, temporal_key_id, secure_frame_number};
      exp_q.push_back({3'h0, 8'h59, nonce_rev(n), p - eo});
      exp_q.push_back({3'h1, eo + 16'h000e, mac_header, eo, sec_reserved, 8'h00});
      b = 128'h0;
      j = 0;
      for (k = 0; k < p; k = k + 1) begin
        b[127-8*j -: 8] = pbyte(k);
        j = j + 1;
        if (j == 16 || k == eo - 1 || k == p - 1) begin
          exp_q.push_back({(k < eo) ? 3'h2 : 3'h3, b});
          b = 128'h0;
          j = 0;
        end
      end
      for (k = 0; k <= nc; k = k + 1)
        exp_q.push_back({3'h4, 8'h01, nonce_rev(n), k[15:0]});
      // Raise the start only once the block shows it is ready for it
      w = 0;
      while (start_ready_q !== 1'b1 && w < 100) begin
        @(posedge clk);
        w = w + 1;
      end
      @(negedge clk);
      frame_start = 1'b1;
      @(posedge clk);
      repeat (hold + 1) @(negedge clk);
      frame_start = 1'b0;
      for (k = 0; k < p; k = k + 1) begin
        pl_valid = 1'b1;
        pl_data = pbyte(k);
        do begin
          @(posedge clk);
          w = w + 1;
        end while (pl_ready_q !== 1'b1 && w < 2000);
        @(negedge clk);
      end
      pl_valid = 1'b0;
      while (frame_done_q !== 1'b1 && w < 4000) begin
        @(posedge clk);
        w = w + 1;
      end
      check(frame_done_q, 131'h1);
      while (exp_q.size() != 0 && w < 6000) begin
        @(posedge clk);
        w = w + 1;
      end
      check(exp_q.size(), 131'h0);
      check(w < 6000, 131'h1);
    end
  endtask
  task t_mixed_pad;
    run_frame(16'd20, 16'd5, 16'd3, 2'h0, 0);
  endtask
  task t_exact_blocks;
    run_frame(16'd32, 16'd16, 16'd1, 2'h1, 0);
  endtask
  task t_full_fifo;
    run_frame(16'd3, 16'd0, 16'd20, 2'h2, 0);
  endtask
  task t_start_refused;
    run_frame(16'd17, 16'd17, 16'd0, 2'h1, 3);
  endtask
  initial begin
    #(25 * 30000);
    errors = errors + 1;
    report_and_stop;
  end
  initial begin
    errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    frame_start = 1'b0;
    pl_valid = 1'b0;
    pl_data = 8'h00;
    stall_mode = 2'h0;
    source_addr = 16'h1a2b;
    destination_addr = 16'h3c4d;
    temporal_key_id = 24'h5e6f70;
    secure_frame_number = 48'h0102_0304_0506;
    mac_header = 80'h8192_a3b4_c5d6_e7f8_0911;
    payload_len = 16'h0000;
    encryption_offset = 16'h0000;
    sec_reserved = 8'h6c;
    ctr_blocks = 16'h0000;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_mixed_pad;
    t_exact_blocks;
    t_full_fifo;
    t_start_refused;
    report_and_stop;
  end
endmodule // tb_top
